// ==== core/ulp_pkg.sv ====
// shared constants for the ulpi device and link ends
`default_nettype none
package ulp_pkg;
	// clocking: system rate and the interface rate derived from it
	localparam int unsigned SYS_HZ     = 100_000_000;
	localparam int unsigned IF_HZ      = 60_000_000;  // interface clock target
	localparam int unsigned IF_DIV_RAW = (SYS_HZ + IF_HZ - 1) / IF_HZ;
	localparam int unsigned IF_DIV     = (IF_DIV_RAW < 2) ? 2 : IF_DIV_RAW;
	localparam logic [3:0]  IF_DIV_MAX = 4'(IF_DIV - 1);
	// start-up and transceiver reset times, in interface ticks
	localparam logic [11:0] PLL_START_TICKS = 12'h0C8;
	localparam logic [7:0]  XRST_TICKS      = 8'h10;
	// worst receive end latency in high-speed bit clocks
	localparam int unsigned RX_END_DELAY     = 4;
	localparam int unsigned RX_END_DELAY_MAX = 43;
	localparam int unsigned RX_END_LIMIT     = 63;
	// command byte: top two bits select the kind of transfer
	localparam logic [1:0] CMD_SPECIAL = 2'h0;
	localparam logic [1:0] CMD_TX      = 2'h1;
	localparam logic [1:0] CMD_WRITE   = 2'h2;
	localparam logic [1:0] CMD_READ    = 2'h3;
	// writable registers: write, set and clear live at base, +1, +2
	localparam int unsigned NUM_RW = 6;
	localparam logic [5:0] RW_BASE [NUM_RW] = '{6'h04, 6'h07, 6'h0A, 6'h0D, 6'h10, 6'h16};
	localparam logic [7:0] RW_RESET [NUM_RW] = '{8'h41, 8'h00, 8'h06, 8'h1F, 8'h1F, 8'h00};
	localparam int unsigned FUNC_SLOT = 0;
	localparam logic [5:0] ADDR_FUNC_WR  = 6'h04;
	localparam logic [5:0] ADDR_FUNC_CLR = 6'h06;
	localparam int unsigned FUNC_XRST_BIT = 5;
	localparam int unsigned FUNC_SUSP_BIT = 6;
	// read-only registers
	localparam logic [5:0] ADDR_ID0     = 6'h00;
	localparam logic [5:0] ADDR_ID3     = 6'h03;
	localparam logic [5:0] ADDR_INT_STS = 6'h13;
	localparam logic [5:0] ADDR_INT_LAT = 6'h14;
	localparam logic [5:0] ADDR_DEBUG   = 6'h15;
	// low power data pin layout
	localparam int unsigned LPM_INT_BIT = 3;
endpackage : ulp_pkg
`default_nettype wire

// ==== core/ulp_if.sv ====
// twelve-pin ulpi link between the device end and the link end
`default_nettype none
interface ulp_if;
	logic       clkOut;   // interface clock, one sys_clk high per period
	logic       dir;      // bus owner: high means device drives
	logic       nxt;      // throttle from the device
	logic       stp;      // stop / wake from the link
	logic [7:0] devData;  // device side data drive
	logic       devOe;    // device drives data
	logic [7:0] lnkData;  // link side data drive
	logic       lnkOe;    // link drives data
	logic [7:0] data;     // resolved bus level, zero when undriven
	assign data = devOe ? devData : (lnkOe ? lnkData : 8'h00);
	modport device (output clkOut, dir, nxt, devData, devOe, input stp, data);
	modport link (input clkOut, dir, nxt, data, output stp, lnkData, lnkOe);
endinterface : ulp_if
`default_nettype wire

// ==== core/ulp_device.sv ====
// ulpi device end: bus arbiter, command decoder and register array
// Summary of operation
// - device makes interface clock, outputs on it
// - dir high: device drives; low: link drives
// - non-zero bus byte starts a transfer; ulp_device ignores non-zero bytes whose top two bits are CMD_SPECIAL
// - dir high when device has data
// - dir held high while not ready
// - one-cycle stp ends stream, prior byte last
// - nxt accepts byte, next byte follows
// - one turnaround cycle per dir change; sleep entry raises dir and devOe on the same tick
// - low power: clock stops, linestate on data
// - low power interrupt on comparator/id change
// - stp wakes device; bring-up ends on the pllCnt countdown alone
// - receive end delay at most 43 clocks
// - one decoder routes to transmitter or registers
// - registers eight bits, defaults at reset
// - transceiver reset leaves registers untouched
// - link avoids undefined register addresses; ulp_link sends any cmdAddr unchecked, and the bench uses 6'h19 and 6'h1A
// - transceiver reset bit self-clears
// - suspend clear enters, exit sets it
`default_nettype none
module ulp_device
	import ulp_pkg::*;
#(
	parameter logic [7:0] ID_BYTE0 = 8'hA5,  // arbitrary identity value
	parameter logic [7:0] ID_BYTE1 = 8'h5A,  // arbitrary identity value
	parameter logic [7:0] ID_BYTE2 = 8'h3C,  // arbitrary identity value
	parameter logic [7:0] ID_BYTE3 = 8'hC3   // arbitrary identity value
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// ulpi pins
	ulp_if.device           bus,
	// transmitter side
	input  wire logic       txAccept,
	output logic [7:0]      txByte,
	output logic            txStrobe,
	output logic            txEnd,
	// receiver side
	input  wire logic       rxValid,
	input  wire logic [7:0] rxData,
	output logic            rxTake,
	// analog side status and control
	input  wire logic [1:0] lineState,
	input  wire logic [3:0] otgComp,
	output logic            xcvrRst,
	output logic            lowPower
);

	typedef enum logic [3:0] {
		ST_PLL, ST_IDLE, ST_TX, ST_WRA, ST_WRS, ST_RDT, ST_RDD, ST_BACK, ST_RXT, ST_RX, ST_LPM
	} ulp_state_e;

	ulp_state_e state;          // protocol state
	logic [3:0] divCnt;         // interface clock divider
	logic       tick;           // one interface period elapsed
	logic [11:0] pllCnt;        // start-up countdown
	logic [7:0] xrstCnt;        // transceiver reset countdown
	logic [5:0] cmdAddr;        // latched register address
	logic [7:0] wrData;         // latched register data
	logic       wrDo;           // register write strobe (one sys_clk)
	logic [7:0] rwReg [NUM_RW]; // writable register storage
	logic [3:0] otgRef;         // comparator snapshot at sleep entry
	logic       lpmIntr;        // low power interrupt level
	logic [7:0] rdMux;          // register read value

	//////////////////////////////////////////////////////////////////////
	// interface clock divider; divCnt keeps counting while asleep, clkOut held low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt <= 4'h0;
			bus.clkOut <= 1'b0;
		end else begin
			divCnt <= (divCnt == IF_DIV_MAX) ? 4'h0 : divCnt + 4'h1;
			bus.clkOut <= (divCnt == IF_DIV_MAX) && (state != ST_LPM);
		end
	end
	assign tick = (divCnt == IF_DIV_MAX);

	//////////////////////////////////////////////////////////////////////
	// read multiplexer over the whole register map
	always_comb begin
		rdMux = 8'h00; // undefined addresses read zero
		case (cmdAddr)
			ADDR_ID0:          rdMux = ID_BYTE0;
			ADDR_ID0 + 6'h01:  rdMux = ID_BYTE1;
			ADDR_ID0 + 6'h02:  rdMux = ID_BYTE2;
			ADDR_ID3:          rdMux = ID_BYTE3;
			ADDR_INT_STS:      rdMux = {4'h0, otgComp};
			ADDR_INT_LAT:      rdMux = 8'h00;
			ADDR_DEBUG:        rdMux = {6'h00, lineState};
			default: begin
				for (int i = 0; i < NUM_RW; i++) begin
					if (cmdAddr >= RW_BASE[i] && cmdAddr <= RW_BASE[i] + 6'h02) begin
						rdMux = rwReg[i];
					end
				end
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// register array: write/set/clear per slot, reset only by rst_n
	generate
		for (genvar g = 0; g < NUM_RW; g++) begin : g_reg
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					rwReg[g] <= RW_RESET[g];
				end else begin
					logic [7:0] nv;
					nv = rwReg[g];
					if (g == FUNC_SLOT && tick && xrstCnt == 8'h01) begin
						nv[FUNC_XRST_BIT] = 1'b0;
					end
					if (g == FUNC_SLOT && state == ST_LPM && bus.stp) begin
						nv[FUNC_SUSP_BIT] = 1'b1;
					end
					if (wrDo && cmdAddr == RW_BASE[g]) begin
						nv = wrData;
					end else if (wrDo && cmdAddr == RW_BASE[g] + 6'h01) begin
						nv = nv | wrData;
					end else if (wrDo && cmdAddr == RW_BASE[g] + 6'h02) begin
						nv = nv & ~wrData;
					end
					rwReg[g] <= nv;
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// transceiver reset timer; touches no register but its own bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			xrstCnt <= 8'h00;
			xcvrRst <= 1'b0;
		end else if (tick) begin
			if (xrstCnt == 8'h00 && rwReg[FUNC_SLOT][FUNC_XRST_BIT]) begin
				xrstCnt <= XRST_TICKS;
			end else if (xrstCnt != 8'h00) begin
				xrstCnt <= xrstCnt - 8'h01;
			end
			xcvrRst <= (xrstCnt != 8'h00) || rwReg[FUNC_SLOT][FUNC_XRST_BIT];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// low power interrupt, watched every sys_clk since no clock runs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			otgRef <= 4'h0;
			lpmIntr <= 1'b0;
		end else if (state != ST_LPM) begin
			otgRef <= otgComp;
			lpmIntr <= 1'b0;
		end else begin
			lpmIntr <= (otgComp != otgRef);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// protocol decoder and bus arbiter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_PLL;
			pllCnt <= PLL_START_TICKS;
			bus.dir <= 1'b1;
			bus.nxt <= 1'b0;
			bus.devData <= 8'h00;
			bus.devOe <= 1'b0;
			cmdAddr <= 6'h00;
			wrData <= 8'h00;
			wrDo <= 1'b0;
			txByte <= 8'h00;
			txStrobe <= 1'b0;
			txEnd <= 1'b0;
			rxTake <= 1'b0;
			lowPower <= 1'b0;
		end else begin
			wrDo <= 1'b0;
			txStrobe <= 1'b0;
			txEnd <= 1'b0;
			rxTake <= 1'b0;
			if (state == ST_LPM) begin
				// no clock: linestate and interrupt on the data pins
				bus.devData <= {4'h0, lpmIntr, 1'b0, lineState};
				if (bus.stp) begin
					bus.dir <= 1'b0;
					bus.devOe <= 1'b0;
					lowPower <= 1'b0;
					state <= ST_IDLE;
				end
			end else if (tick) begin
				case (state)
					ST_PLL: begin
						// not ready: keep the bus so the link cannot talk
						if (pllCnt != 12'h000) begin
							pllCnt <= pllCnt - 12'h001;
						end else begin
							bus.dir <= 1'b0;
							state <= ST_IDLE;
						end
					end
					ST_IDLE: begin
						bus.devOe <= 1'b0;
						if (!rwReg[FUNC_SLOT][FUNC_SUSP_BIT]) begin
							bus.dir <= 1'b1;
							bus.devOe <= 1'b1;
							lowPower <= 1'b1;
							state <= ST_LPM;
						end else if (bus.data != 8'h00) begin
							// link command; rule 8 holds since we own no turnaround here
							cmdAddr <= bus.data[5:0];
							bus.nxt <= 1'b1;
							case (bus.data[7:6])
								CMD_TX: begin
									txByte <= bus.data;
									txStrobe <= 1'b1;
									state <= ST_TX;
								end
								CMD_WRITE: state <= ST_WRA;
								CMD_READ:  state <= ST_RDT;
								default:   bus.nxt <= 1'b0; // special: ignored
							endcase
						end else if (rxValid) begin
							bus.dir <= 1'b1;
							state <= ST_RXT;
						end
					end
					ST_TX: begin
						if (bus.stp) begin
							txEnd <= 1'b1;
							bus.nxt <= 1'b0;
							state <= ST_IDLE;
						end else begin
							bus.nxt <= txAccept;
							if (txAccept) begin
								txByte <= bus.data;
								txStrobe <= 1'b1;
							end
						end
					end
					ST_WRA: begin
						wrData <= bus.data;
						state <= ST_WRS;
					end
					ST_WRS: begin
						bus.nxt <= 1'b0;
						wrDo <= bus.stp;
						state <= ST_IDLE;
					end
					ST_RDT: begin
						bus.nxt <= 1'b0;
						bus.dir <= 1'b1;
						state <= ST_RDD;
					end
					ST_RDD: begin
						bus.devOe <= 1'b1;
						bus.devData <= rdMux;
						state <= ST_BACK;
					end
					ST_RXT: begin
						bus.devOe <= 1'b1;
						if (rxValid) begin
							bus.devData <= rxData;
							bus.nxt <= 1'b1;
							rxTake <= 1'b1;
							state <= ST_RX;
						end else begin
							state <= ST_BACK;
						end
					end
					ST_RX: begin
						// straight through, so end latency is RX_END_DELAY bit clocks
						if (rxValid && RX_END_DELAY <= RX_END_DELAY_MAX) begin
							bus.devData <= rxData;
							rxTake <= 1'b1;
						end else begin
							bus.nxt <= 1'b0;
							bus.dir <= 1'b0;
							bus.devOe <= 1'b0;
							state <= ST_IDLE;
						end
					end
					ST_BACK: begin
						bus.dir <= 1'b0;
						bus.devOe <= 1'b0;
						state <= ST_IDLE;
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule : ulp_device
`default_nettype wire

// ==== core/ulp_link.sv ====
// ulpi link end: issues commands and stream data, watches the device
`default_nettype none
module ulp_link
	import ulp_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// ulpi pins
	ulp_if.link             bus,
	// command request
	input  wire logic       cmdValid,
	input  wire logic [1:0] cmdOp,
	input  wire logic [5:0] cmdAddr,
	input  wire logic [7:0] cmdData,
	output logic            cmdReady,
	// transmit stream
	input  wire logic [7:0] txData,
	input  wire logic       txValid,
	input  wire logic       txLast,
	output logic            txTake,
	// answers
	output logic [7:0]      rdData,
	output logic            rdValid,
	output logic [7:0]      rxData,
	output logic            rxValid,
	// low power
	input  wire logic       wakeReq,
	output logic            lowPower,
	output logic [1:0]      lineSeen,
	output logic            lpmIntr
);

	typedef enum logic [2:0] {
		LS_IDLE, LS_TX, LS_WR, LS_WRD, LS_STP, LS_RD, LS_RDW, LS_LPM
	} ulp_lstate_e;

	ulp_lstate_e state;   // link protocol state
	logic       dirPrev;  // dir at previous interface edge
	logic       lastSent; // final stream byte already on the bus
	logic       sleepNext;// the finished write put the device to sleep
	logic [7:0] wrHold;   // data byte of a register write
	logic       t;        // interface edge seen

	assign t = bus.clkOut;

	//////////////////////////////////////////////////////////////////////
	// link protocol; data changes only on interface edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= LS_IDLE;
			dirPrev <= 1'b1;
			lastSent <= 1'b0;
			sleepNext <= 1'b0;
			wrHold <= 8'h00;
			bus.stp <= 1'b1;
			bus.lnkData <= 8'h00;
			bus.lnkOe <= 1'b0;
			cmdReady <= 1'b0;
			txTake <= 1'b0;
			rdData <= 8'h00;
			rdValid <= 1'b0;
			rxData <= 8'h00;
			rxValid <= 1'b0;
			lowPower <= 1'b0;
			lineSeen <= 2'h0;
			lpmIntr <= 1'b0;
		end else begin
			txTake <= 1'b0;
			rdValid <= 1'b0;
			rxValid <= 1'b0;
			if (state == LS_LPM) begin
				// device clock stopped: sample every cycle
				lineSeen <= bus.data[1:0];
				lpmIntr <= bus.data[LPM_INT_BIT];
				bus.stp <= wakeReq || bus.stp;
				dirPrev <= bus.dir;
				// leave only on a fall of dir: it is still low when we get here
				if (!bus.dir && dirPrev) begin
					bus.stp <= 1'b0;
					lowPower <= 1'b0;
					dirPrev <= 1'b1;
					state <= LS_IDLE;
				end
			end else if (t) begin
				dirPrev <= bus.dir;
				bus.lnkOe <= !bus.dir && !dirPrev;
				if (!bus.dir) begin
					bus.stp <= 1'b0;
				end
				case (state)
					LS_IDLE: begin
						bus.lnkData <= 8'h00;
						cmdReady <= !bus.dir && !dirPrev;
						if (bus.dir && dirPrev && bus.nxt) begin
							rxData <= bus.data;
							rxValid <= 1'b1;
						end else if (!bus.dir && !dirPrev && cmdValid && cmdReady) begin
							cmdReady <= 1'b0;
							wrHold <= cmdData;
							lastSent <= 1'b0;
							sleepNext <= (cmdAddr == ADDR_FUNC_WR && !cmdData[FUNC_SUSP_BIT])
								|| (cmdAddr == ADDR_FUNC_CLR && cmdData[FUNC_SUSP_BIT]);
							case (cmdOp)
								CMD_TX: begin
									bus.lnkData <= {CMD_TX, 2'h0, cmdData[3:0]};
									state <= LS_TX;
								end
								CMD_WRITE: begin
									bus.lnkData <= {CMD_WRITE, cmdAddr};
									state <= LS_WR;
								end
								CMD_READ: begin
									bus.lnkData <= {CMD_READ, cmdAddr};
									state <= LS_RD;
								end
								default: cmdReady <= 1'b1;
							endcase
						end
					end
					LS_TX: begin
						if (bus.nxt) begin
							if (lastSent || !txValid) begin
								bus.lnkData <= 8'h00;
								bus.stp <= 1'b1;
								sleepNext <= 1'b0;
								state <= LS_STP;
							end else begin
								bus.lnkData <= txData;
								txTake <= 1'b1;
								lastSent <= txLast;
							end
						end
					end
					LS_WR: begin
						if (bus.nxt) begin
							bus.lnkData <= wrHold;
							state <= LS_WRD;
						end
					end
					LS_WRD: begin
						if (bus.nxt) begin
							bus.lnkData <= 8'h00;
							bus.stp <= 1'b1;
							state <= LS_STP;
						end
					end
					LS_STP: begin
						bus.stp <= 1'b0;
						bus.lnkData <= 8'h00;
						if (sleepNext) begin
							bus.lnkOe <= 1'b0;
							lowPower <= 1'b1;
							state <= LS_LPM;
						end else begin
							state <= LS_IDLE;
						end
					end
					LS_RD: begin
						if (bus.nxt) begin
							bus.lnkData <= 8'h00;
							state <= LS_RDW;
						end
					end
					LS_RDW: begin
						// first dir-high edge is turnaround; data follows
						if (bus.dir && dirPrev) begin
							rdData <= bus.data;
							rdValid <= 1'b1;
							state <= LS_IDLE;
						end
					end
					default: state <= LS_IDLE;
				endcase
			end
		end
	end

endmodule : ulp_link
`default_nettype wire

// ==== testbench/ulp_checker_sva.sv ====
// concurrent checks on the ulpi pins between device and link ends
`default_nettype none
module ulp_checker (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// ulpi pins
	input wire logic       clkOut,
	input wire logic       dir,
	input wire logic       nxt,
	input wire logic       stp,
	input wire logic       devOe,
	input wire logic [7:0] lnkData,
	input wire logic       lnkOe,
	input wire logic [7:0] data
);
	timeunit 1ns;
	timeprecision 100ps;
	// one domain, so clock and reset are stated once
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////
	// ownership and turnaround
	a_no_clash: assert property (!(devOe && lnkOe))
		else $error("both ends drive the data bus");
	a_dev_owner: assert property (devOe |-> dir)
		else $error("device drives data with dir low");
	a_link_yield: assert property ($rose(dir) |-> ##[0:2] !lnkOe)
		else $error("link kept driving after dir rose");
	a_turn_idle: assert property ($fell(dir) |-> !lnkOe [*2])
		else $error("link drove in the turnaround period");
	a_start_dir: assert property ($rose(rst_n) |-> dir [*8])
		else $error("dir not held high during start-up");
	////////////////////////////////////////////////////////////
	// clocking of the interface
	a_clk_pulse: assert property (clkOut |=> !clkOut)
		else $error("interface clock high too long");
	a_clk_period: assert property ($fell(clkOut) ##1 !devOe |-> clkOut)
		else $error("interface clock missed a period");
	a_nxt_edge: assert property ($changed(nxt) |-> clkOut)
		else $error("nxt moved off the interface edge");
	////////////////////////////////////////////////////////////
	// stop and throttle
	a_stp_pulse: assert property ($rose(stp) && !dir |=> stp ##1 !stp)
		else $error("stop not one interface period");
	a_stp_zero: assert property (stp && lnkOe |-> lnkData == 8'h00)
		else $error("link data not idle with stop");
	a_cmd_nxt: assert property (lnkOe && !dir && !nxt && data[7] |-> ##[1:4] nxt)
		else $error("register command not accepted");
	// main traffic kinds seen at least once
	c_write: cover property (lnkOe && data[7:6] == 2'h2);
	c_dev_drive: cover property ($rose(devOe));
	c_wake: cover property ($rose(stp) && dir);
endmodule : ulp_checker
`default_nettype wire

// ==== testbench/ulpi_phy_link_interface_test.sv ====
// self-checking bench joining the ulpi device end and link end
`default_nettype none
module ulpi_phy_link_interface_test import ulp_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] ID0 = 8'h96;  // arbitrary identity value
	logic       sys_clk;      // system clock
	logic       rst_n;        // async reset, low active
	logic       txAccept;     // transmitter ready
	logic [7:0] txByte;       // byte to transmitter
	logic       txStrobe;     // byte pulse
	logic       txEnd;        // stream end pulse
	logic       devRxValid;   // receive byte waiting
	logic [7:0] devRxData;    // receive byte
	logic       rxTake;       // receive byte consumed
	logic [1:0] lineState;    // analog line state
	logic [3:0] otgComp;      // comparators and id
	logic       xcvrRst;      // transceiver reset
	logic       devLowPower;  // device asleep
	logic       cmdValid;     // command request
	logic [1:0] cmdOp;        // command kind
	logic [5:0] cmdAddr;      // register address
	logic [7:0] cmdData;      // write data or pid
	logic       cmdReady;     // link can take command
	logic [7:0] txData;       // stream byte
	logic       txValid;      // stream byte valid
	logic       txLast;       // final stream byte
	logic       txTake;       // stream byte consumed
	logic [7:0] rdData;       // register read result
	logic       rdValid;      // read result pulse
	logic [7:0] lnkRxData;    // received byte at link
	logic       lnkRxValid;   // received byte pulse
	logic       wakeReq;      // wake request
	logic       lnkLowPower;  // link sees low power
	logic [1:0] lineSeen;     // line state at link
	logic       lpmIntr;      // low power interrupt
	int         err_count;       // mismatches
	int         samples_checked; // comparisons
	////////////////////////////////////////////////////////////
	// the two ends face each other across one interface
	ulp_if ifc ();
	ulp_device #(.ID_BYTE0(ID0)) ulp_device_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(ifc),
		.txAccept(txAccept), .txByte(txByte), .txStrobe(txStrobe), .txEnd(txEnd),
		.rxValid(devRxValid), .rxData(devRxData), .rxTake(rxTake), .lineState(lineState),
		.otgComp(otgComp), .xcvrRst(xcvrRst), .lowPower(devLowPower));
	ulp_link ulp_link_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(ifc), .cmdValid(cmdValid),
		.cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
		.txData(txData), .txValid(txValid), .txLast(txLast), .txTake(txTake),
		.rdData(rdData), .rdValid(rdValid), .rxData(lnkRxData), .rxValid(lnkRxValid),
		.wakeReq(wakeReq), .lowPower(lnkLowPower), .lineSeen(lineSeen), .lpmIntr(lpmIntr));
	ulp_checker ulp_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clkOut(ifc.clkOut),
		.dir(ifc.dir), .nxt(ifc.nxt), .stp(ifc.stp), .devOe(ifc.devOe),
		.lnkData(ifc.lnkData), .lnkOe(ifc.lnkOe), .data(ifc.data));
	////////////////////////////////////////////////////////////
	// helpers: compare, bounded wait, command issue
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// flag selected by code, so one wait loop serves all
	function automatic logic pick(input int s);
		case (s)
			0: return cmdReady;
			1: return rdValid;
			2: return xcvrRst;
			3: return lnkLowPower;
			4: return lpmIntr;
			5: return cmdReady && ifc.clkOut;
			default: return ifc.dir;
		endcase
	endfunction
	// returns on the edge where the flag was seen; a hang ends the run
	task automatic waitVal(input int s, input logic v);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pick(s) !== v && n < 3000);
		if (n >= 3000) begin
			err_count++;
			summarize();
		end
	endtask
	// request held until the link takes it on an interface edge
	task automatic doCmd(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d);
		cmdOp = op;
		cmdAddr = a;
		cmdData = d;
		cmdValid = 1'b1;
		waitVal(5, 1'b1);
		#1 cmdValid = 1'b0;
	endtask
	task automatic readReg(input logic [5:0] a, input logic [7:0] e);
		doCmd(CMD_READ, a, 8'h00);
		waitVal(1, 1'b1);
		check(rdData, e);
		#1;
	endtask
	task automatic writeReg(input logic [5:0] a, input logic [7:0] d);
		doCmd(CMD_WRITE, a, d);
	endtask
	////////////////////////////////////////////////////////////
	// scenarios
	task automatic testStartup();
		repeat (8) @(posedge sys_clk);
		check({7'h00, ifc.dir}, 8'h01);
		waitVal(0, 1'b1);
		check({7'h00, ifc.dir}, 8'h00);
		check({7'h00, ifc.stp}, 8'h00);
		#1;
	endtask
	// defaults, id, set and clear aliases, unmapped places
	task automatic testRegs();
		for (int i = 0; i < NUM_RW; i++) begin
			readReg(RW_BASE[i], RW_RESET[i]);
		end
		readReg(ADDR_ID0, ID0);
		readReg(6'h19, 8'h00);
		readReg(ADDR_INT_STS, 8'h05);
		readReg(ADDR_INT_LAT, 8'h00);
		readReg(ADDR_DEBUG, 8'h02);
		writeReg(6'h16, 8'h5A);
		readReg(6'h16, 8'h5A);
		writeReg(6'h17, 8'h81);
		readReg(6'h18, 8'hDB);
		writeReg(6'h18, 8'h0A);
		readReg(6'h16, 8'hD1);
		writeReg(6'h1A, 8'hFF);
		readReg(6'h1A, 8'h00);
	endtask
	// reset bit pulses, clears itself, leaves registers alone
	task automatic testXrst();
		writeReg(ADDR_FUNC_WR, 8'h61);
		waitVal(2, 1'b1);
		waitVal(2, 1'b0);
		#1;
		readReg(ADDR_FUNC_WR, 8'h41);
		readReg(6'h16, 8'hD1);
	endtask
	// transmit stream, transmitter stalled at first
	task automatic testTx();
		logic [7:0] q [$];
		int k;
		int n;
		k = 0;
		n = 0;
		txAccept = 1'b0;
		txData = 8'h11;
		txLast = 1'b0;
		txValid = 1'b1;
		fork
			doCmd(CMD_TX, 6'h00, 8'h01);
			repeat (300) begin
				@(posedge sys_clk);
				if (txTake && k < 3) begin
					k++;
					#1 txData = 8'(8'h11 * (k + 1));
					txLast = (k == 2);
					txValid = (k < 3);
				end
			end
			do begin
				@(posedge sys_clk);
				n++;
				if (n == 6) txAccept <= 1'b1;
				if (txStrobe) q.push_back(txByte);
			end while (!txEnd && n < 600);
		join
		// stream end never seen: a hang, so stop here
		if (n >= 600) begin
			err_count++;
			summarize();
		end
		check(8'(q.size()), 8'h04);
		check(q[0], 8'h41);
		for (int i = 1; i < 4; i++) begin
			check(q[i], 8'(8'h11 * i));
		end
		#1;
	endtask
	// device takes the bus, then hands it back
	task automatic testRx();
		logic [7:0] q [$];
		int j;
		int n;
		j = 0;
		n = 0;
		devRxData = 8'h3C;
		devRxValid = 1'b1;
		fork
			repeat (300) begin
				@(posedge sys_clk);
				if (rxTake && j < 3) begin
					j++;
					#1 devRxData = 8'(8'h3C + j);
					devRxValid = (j < 3);
				end
			end
			do begin
				@(posedge sys_clk);
				n++;
				if (lnkRxValid) q.push_back(lnkRxData);
			end while (q.size() < 3 && n < 600);
		join
		// bytes never arrived: a hang, so stop here
		if (n >= 600) begin
			err_count++;
			summarize();
		end
		for (int i = 0; i < 3; i++) begin
			check(q[i], 8'(8'h3C + i));
		end
		waitVal(6, 1'b0);
		#1;
	endtask
	// sleep via clear alias, interrupt, wake by stop
	task automatic testLpm();
		int n;
		n = 0;
		writeReg(ADDR_FUNC_CLR, 8'h40);
		waitVal(3, 1'b1);
		// skip the last clock pulse, launched on the sleep entry edge
		@(posedge sys_clk);
		repeat (20) begin
			@(posedge sys_clk);
			n += int'(ifc.clkOut);
		end
		check(8'(n), 8'h00);
		check({6'h00, ifc.data[1:0]}, 8'h02);
		check({6'h00, lineSeen}, 8'h02);
		check({7'h00, devLowPower}, 8'h01);
		check({7'h00, lpmIntr}, 8'h00);
		#1 otgComp = 4'h4;
		waitVal(4, 1'b1);
		#1 wakeReq = 1'b1;
		waitVal(3, 1'b0);
		#1 wakeReq = 1'b0;
		otgComp = 4'h5;
		readReg(ADDR_FUNC_WR, 8'h41);
	endtask
	////////////////////////////////////////////////////////////
	// verdict: the only place the run ends
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// 100 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// reset, then scenarios in order
	initial begin
		err_count = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		{txAccept, devRxValid, cmdValid, txValid, txLast, wakeReq} = 6'h00;
		{devRxData, cmdData, txData} = 24'h000000;
		{cmdOp, cmdAddr} = 8'h00;
		lineState = 2'h2;
		otgComp = 4'h5;
		repeat (8) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		testStartup();
		testRegs();
		testXrst();
		testTx();
		testRx();
		testLpm();
		summarize();
	end
endmodule : ulpi_phy_link_interface_test
`default_nettype wire
